// ==== src/pesm_defines.svh ====
`ifndef PESM_DEFINES_SVH
`define PESM_DEFINES_SVH

// Register byte addresses
`define PESM_ADDR_PHASE_SRC 16'hE600
`define PESM_ADDR_NOLOAD 16'hE608
`define PESM_ADDR_MASK 16'hE50C
`define PESM_ADDR_STATUS 16'hE510
`define PESM_ADDR_THRESH 16'hE514

// Status and mask bit positions
`define PESM_BIT_NL_TOT 0
`define PESM_BIT_NL_FUND 1
`define PESM_BIT_NL_APP 2
`define PESM_BIT_RST_DONE 15
`define PESM_BIT_SAG 16
`define PESM_BIT_OC 17
`define PESM_BIT_OV 18
`define PESM_BIT_SEQ 19
`define PESM_BIT_MISM 20
`define PESM_BIT_PKI 23
`define PESM_BIT_PKV 24
`define PESM_BIT_SIG 25

// Writable mask bits, implemented status bits, reserved read as zero
`define PESM_MASK_WR 32'h039F_FFFF
`define PESM_STATUS_IMPL 32'h039F_8007
`define PESM_PHSRC_IMPL 16'h7E38
`define PESM_MASK_RST 32'h0000_0000
`define PESM_FORCE_EN 32'h0000_8000

// Bus responses
`define PESM_RESP_OKAY 2'h0
`define PESM_RESP_SLVERR 2'h2

`endif

// ==== src/pesm_pkg.sv ====
package pesm_pkg;

    typedef enum logic [1:0] {
        PESM_SEQ_IDLE = 2'b00,
        PESM_SEQ_ARMED = 2'b01
    } pesm_seq_t;

    typedef struct packed {
        logic aw_held;
        logic [15:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] mask;
        logic [31:0] status;
        logic [15:0] phase_src;
        logic [8:0] noload;
        logic [23:0] thresh;
        logic [31:0] sig_prev;
        logic sig_primed;
        pesm_seq_t seq;
        logic irq_b;
    } pesm_state_t;

endpackage : pesm_pkg

// ==== src/pesm_top.sv ====
`timescale 1ns/1ps
`include "pesm_defines.svh"

module pesm_top #(
    parameter bit P_HAS_FUND = 1'b1,
    parameter bit P_ACTIVE_ONLY = 1'b0
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [15:0] I_AWADDR,
    input wire logic I_WVALID,
    output logic O_WREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    output logic O_BVALID,
    input wire logic I_BREADY,
    output logic [1:0] O_BRESP,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    input wire logic [15:0] I_ARADDR,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    input wire logic [2:0] I_SAG_PH,
    input wire logic [2:0] I_OVERCURRENT_PH,
    input wire logic [2:0] I_OVERVOLTAGE_PH,
    input wire logic I_ZX_RISE_A,
    input wire logic I_ZX_RISE_B,
    input wire logic I_ZX_RISE_C,
    input wire logic I_CURRENT_VLD,
    input wire logic [23:0] I_PHASE_CURRENT_SUM,
    input wire logic [23:0] I_NEUTRAL_CURRENT_SAMPLE,
    input wire logic I_CURRENT_PEAK_END,
    input wire logic I_VOLTAGE_PEAK_END,
    input wire logic [31:0] I_CONFIG_SIGNATURE,
    input wire logic I_RESET_DONE,
    input wire logic [2:0] I_TOTAL_NOLOAD_ACT,
    input wire logic [2:0] I_TOTAL_NOLOAD_REACT,
    input wire logic [2:0] I_FUND_NOLOAD,
    input wire logic [2:0] I_APPARENT_NOLOAD,
    output logic O_IRQ_B
);
    import pesm_pkg::*;

    pesm_state_t s_r;
    pesm_state_t s_nxt;

    logic aw_ok;
    logic w_ok;
    logic wr_go;
    logic [15:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] set_ev;
    logic [31:0] clr_ev;
    logic [2:0] nl_tot;
    logic [2:0] nl_fund;
    logic [8:0] nl_cur;
    logic [24:0] mism_abs;

    function automatic logic [31:0] pesm_lanes(input logic [3:0] strb);
        pesm_lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : pesm_lanes

    function automatic logic [31:0] pesm_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        pesm_merge = (old_v & ~pesm_lanes(strb)) | (new_v & pesm_lanes(strb));
    endfunction : pesm_merge

    function automatic logic [31:0] pesm_enabled(input logic [31:0] m);
        // Reset-done cannot be masked, whatever bit 15 holds
        pesm_enabled = (m | `PESM_FORCE_EN) & `PESM_STATUS_IMPL;
    endfunction : pesm_enabled

    function automatic logic [24:0] pesm_abs_diff(input logic [23:0] a,
                                                  input logic [23:0] b);
        logic [24:0] d;
        d = {a[23], a} - {b[23], b};
        pesm_abs_diff = d[24] ? (25'h000_0000 - d) : d;
    endfunction : pesm_abs_diff

    // Each ready only while its own channel has nothing parked, so a stalled response back-pressures
    assign O_AWREADY = !s_r.aw_held && !s_r.bvalid;
    assign O_WREADY = !s_r.w_held && !s_r.bvalid;
    assign O_ARREADY = !s_r.rvalid;
    assign O_BVALID = s_r.bvalid;
    assign O_BRESP = s_r.bresp;
    assign O_RVALID = s_r.rvalid;
    assign O_RDATA = s_r.rdata;
    assign O_RRESP = s_r.rresp;
    assign O_IRQ_B = s_r.irq_b;

    always_comb begin
        s_nxt = s_r;

        // No-load levels per phase
        nl_tot = P_ACTIVE_ONLY ? I_TOTAL_NOLOAD_ACT
                               : (I_TOTAL_NOLOAD_ACT & I_TOTAL_NOLOAD_REACT);
        nl_fund = P_HAS_FUND ? I_FUND_NOLOAD : 3'h0;
        nl_cur = {I_APPARENT_NOLOAD, nl_fund, nl_tot};

        set_ev = 32'h0000_0000;
        // A phase newly entering no-load raises its group flag in the same edge
        set_ev[`PESM_BIT_NL_TOT] = |(nl_cur[2:0] & ~s_r.noload[2:0]);
        set_ev[`PESM_BIT_NL_FUND] = |(nl_cur[5:3] & ~s_r.noload[5:3]);
        set_ev[`PESM_BIT_NL_APP] = |(nl_cur[8:6] & ~s_r.noload[8:6]);
        set_ev[`PESM_BIT_RST_DONE] = I_RESET_DONE;
        set_ev[`PESM_BIT_SAG] = |I_SAG_PH;
        set_ev[`PESM_BIT_OC] = |I_OVERCURRENT_PH;
        set_ev[`PESM_BIT_OV] = |I_OVERVOLTAGE_PH;

        // Phase order watch: after A rises, B must rise before C
        case (s_r.seq)
            PESM_SEQ_IDLE: begin
                if (I_ZX_RISE_A) begin
                    s_nxt.seq = PESM_SEQ_ARMED;
                end
            end
            PESM_SEQ_ARMED: begin
                if (I_ZX_RISE_B) begin
                    s_nxt.seq = PESM_SEQ_IDLE;
                end else if (I_ZX_RISE_C) begin
                    set_ev[`PESM_BIT_SEQ] = 1'b1;
                    s_nxt.seq = PESM_SEQ_IDLE;
                end
            end
            default: begin
                s_nxt.seq = PESM_SEQ_IDLE;
            end
        endcase

        mism_abs = pesm_abs_diff(I_PHASE_CURRENT_SUM, I_NEUTRAL_CURRENT_SAMPLE);
        set_ev[`PESM_BIT_MISM] = I_CURRENT_VLD && (mism_abs > {1'b0, s_r.thresh});
        set_ev[`PESM_BIT_PKI] = I_CURRENT_PEAK_END;
        set_ev[`PESM_BIT_PKV] = I_VOLTAGE_PEAK_END;
        // First sample after reset only primes the compare, so no false change
        set_ev[`PESM_BIT_SIG] = s_r.sig_primed
                                && (I_CONFIG_SIGNATURE != s_r.sig_prev);
        s_nxt.sig_prev = I_CONFIG_SIGNATURE;
        s_nxt.sig_primed = 1'b1;

        // Write channel: address and data may arrive in either order
        aw_ok = s_r.aw_held || (I_AWVALID && O_AWREADY);
        w_ok = s_r.w_held || (I_WVALID && O_WREADY);
        wr_addr = s_r.aw_held ? s_r.aw_addr : I_AWADDR;
        wr_data = s_r.w_held ? s_r.w_data : I_WDATA;
        wr_strb = s_r.w_held ? s_r.w_strb : I_WSTRB;
        wr_go = aw_ok && w_ok && !s_r.bvalid;
        clr_ev = 32'h0000_0000;

        if (wr_go) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `PESM_RESP_OKAY;
            case ({wr_addr[15:2], 2'b00})
                `PESM_ADDR_MASK: begin
                    s_nxt.mask = pesm_merge(s_r.mask, wr_data, wr_strb)
                                 & `PESM_MASK_WR;
                end
                `PESM_ADDR_STATUS: begin
                    clr_ev = wr_data & pesm_lanes(wr_strb);
                end
                `PESM_ADDR_THRESH: begin
                    s_nxt.thresh = 24'(pesm_merge({8'h00, s_r.thresh}, wr_data,
                                                  wr_strb));
                end
                `PESM_ADDR_PHASE_SRC, `PESM_ADDR_NOLOAD: begin
                    s_nxt.bresp = `PESM_RESP_OKAY;
                end
                default: begin
                    s_nxt.bresp = `PESM_RESP_SLVERR;
                end
            endcase
        end else begin
            if (I_AWVALID && O_AWREADY) begin
                s_nxt.aw_held = 1'b1;
                s_nxt.aw_addr = I_AWADDR;
            end
            if (I_WVALID && O_WREADY) begin
                s_nxt.w_held = 1'b1;
                s_nxt.w_data = I_WDATA;
                s_nxt.w_strb = I_WSTRB;
            end
        end
        if (s_r.bvalid && I_BREADY) begin
            s_nxt.bvalid = 1'b0;
        end

        // Set beats clear on the same edge
        s_nxt.status = ((s_r.status & ~clr_ev) | set_ev) & `PESM_STATUS_IMPL;

        // Phase sources follow their flag: cleared only with it
        s_nxt.phase_src[5:3] = (s_r.phase_src[5:3] & {3{!clr_ev[`PESM_BIT_OC]}})
                               | I_OVERCURRENT_PH;
        s_nxt.phase_src[11:9] = (s_r.phase_src[11:9] & {3{!clr_ev[`PESM_BIT_OV]}})
                                | I_OVERVOLTAGE_PH;
        s_nxt.phase_src[14:12] = (s_r.phase_src[14:12] & {3{!clr_ev[`PESM_BIT_SAG]}})
                                 | I_SAG_PH;
        s_nxt.phase_src = s_nxt.phase_src & `PESM_PHSRC_IMPL;
        s_nxt.noload = nl_cur;

        s_nxt.irq_b = ~|(s_nxt.status & pesm_enabled(s_nxt.mask));

        // Read channel
        if (I_ARVALID && O_ARREADY) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = `PESM_RESP_OKAY;
            case ({I_ARADDR[15:2], 2'b00})
                `PESM_ADDR_PHASE_SRC: s_nxt.rdata = {16'h0000, s_r.phase_src};
                `PESM_ADDR_NOLOAD: s_nxt.rdata = {23'h00_0000, s_r.noload};
                `PESM_ADDR_MASK: s_nxt.rdata = s_r.mask;
                `PESM_ADDR_STATUS: s_nxt.rdata = s_r.status;
                `PESM_ADDR_THRESH: s_nxt.rdata = {8'h00, s_r.thresh};
                default: begin
                    s_nxt.rdata = 32'h0000_0000;
                    s_nxt.rresp = `PESM_RESP_SLVERR;
                end
            endcase
        end else if (s_r.rvalid && I_RREADY) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            s_r <= '0;
            s_r.irq_b <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking pesm_cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_B);

    property p_sag_irq;
        s_r.status[`PESM_BIT_SAG] && s_r.mask[`PESM_BIT_SAG] |-> !O_IRQ_B;
    endproperty
    a_sag_irq: assert property (p_sag_irq) else $error("sag not signalled");

    property p_oc_src;
        (I_OVERCURRENT_PH != 3'h0)
            |=> s_r.status[`PESM_BIT_OC]
                && ((s_r.phase_src[5:3] & $past(I_OVERCURRENT_PH))
                    == $past(I_OVERCURRENT_PH));
    endproperty
    a_oc_src: assert property (p_oc_src) else $error("overcurrent source lost");

    property p_ov_src;
        (I_OVERVOLTAGE_PH != 3'h0)
            |=> s_r.status[`PESM_BIT_OV]
                && ((s_r.phase_src[11:9] & $past(I_OVERVOLTAGE_PH))
                    == $past(I_OVERVOLTAGE_PH));
    endproperty
    a_ov_src: assert property (p_ov_src) else $error("overvoltage source lost");

    property p_sag_src;
        (I_SAG_PH != 3'h0)
            |=> s_r.status[`PESM_BIT_SAG]
                && ((s_r.phase_src[14:12] & $past(I_SAG_PH)) == $past(I_SAG_PH));
    endproperty
    a_sag_src: assert property (p_sag_src) else $error("sag source lost");

    property p_seq_err;
        s_r.seq == PESM_SEQ_ARMED && I_ZX_RISE_C && !I_ZX_RISE_B
            |=> s_r.status[`PESM_BIT_SEQ] && s_r.seq == PESM_SEQ_IDLE;
    endproperty
    a_seq_err: assert property (p_seq_err) else $error("phase order miss");

    property p_sig_change;
        s_r.sig_primed && (I_CONFIG_SIGNATURE != s_r.sig_prev)
            |=> s_r.status[`PESM_BIT_SIG];
    endproperty
    a_sig_change: assert property (p_sig_change) else $error("signature change lost");

    property p_rsvd_zero;
        ((s_r.phase_src & ~`PESM_PHSRC_IMPL) == 16'h0000)
            && ((s_r.mask & ~`PESM_MASK_WR) == 32'h0000_0000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

    property p_nl_total;
        (s_r.noload[2:0] & ~$past(s_r.noload[2:0])) != 3'h0
            |-> s_r.status[`PESM_BIT_NL_TOT];
    endproperty
    a_nl_total: assert property (p_nl_total) else $error("no-load flag missing");

    property p_fund_zero;
        1'b1 |=> s_r.noload[5:3] == (P_HAS_FUND ? $past(I_FUND_NOLOAD) : 3'h0);
    endproperty
    a_fund_zero: assert property (p_fund_zero) else $error("fundamental bits set");

    property p_nl_fund_set;
        P_HAS_FUND && ((I_FUND_NOLOAD & ~s_r.noload[5:3]) != 3'h0)
            |=> s_r.status[`PESM_BIT_NL_FUND];
    endproperty
    a_nl_fund_set: assert property (p_nl_fund_set) else $error("fund flag missing");

    property p_nl_app;
        (I_APPARENT_NOLOAD & ~s_r.noload[8:6]) != 3'h0
            |=> s_r.status[`PESM_BIT_NL_APP]
                && (s_r.noload[8:6] == $past(I_APPARENT_NOLOAD));
    endproperty
    a_nl_app: assert property (p_nl_app) else $error("apparent flag missing");

    property p_nl_basis;
        1'b1 |=> s_r.noload[2:0]
                 == ($past(I_TOTAL_NOLOAD_ACT)
                     & (P_ACTIVE_ONLY ? 3'h7 : $past(I_TOTAL_NOLOAD_REACT)));
    endproperty
    a_nl_basis: assert property (p_nl_basis) else $error("no-load basis wrong");

    property p_oc_irq;
        s_r.status[`PESM_BIT_OC] && s_r.mask[`PESM_BIT_OC] |-> !O_IRQ_B;
    endproperty
    a_oc_irq: assert property (p_oc_irq) else $error("overcurrent not signalled");

    property p_ov_irq;
        s_r.status[`PESM_BIT_OV] && s_r.mask[`PESM_BIT_OV] |-> !O_IRQ_B;
    endproperty
    a_ov_irq: assert property (p_ov_irq) else $error("overvoltage not signalled");

    // Positive side of the difference only; the logic folds both signs
    property p_mism_set;
        I_CURRENT_VLD && (($signed(I_PHASE_CURRENT_SUM) - $signed(I_NEUTRAL_CURRENT_SAMPLE))
                          > $signed({1'b0, s_r.thresh}))
            |=> s_r.status[`PESM_BIT_MISM];
    endproperty
    a_mism_set: assert property (p_mism_set) else $error("mismatch flag missing");

    property p_pki_set;
        I_CURRENT_PEAK_END |=> s_r.status[`PESM_BIT_PKI];
    endproperty
    a_pki_set: assert property (p_pki_set) else $error("current peak end lost");

    property p_pkv_set;
        I_VOLTAGE_PEAK_END |=> s_r.status[`PESM_BIT_PKV];
    endproperty
    a_pkv_set: assert property (p_pkv_set) else $error("voltage peak end lost");

    property p_rst_done;
        I_RESET_DONE |=> s_r.status[`PESM_BIT_RST_DONE] && !O_IRQ_B;
    endproperty
    a_rst_done: assert property (p_rst_done) else $error("reset done masked");

    property p_irq_release;
        (s_r.status & pesm_enabled(s_r.mask)) == 32'h0000_0000 |-> O_IRQ_B;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq stuck low");

endmodule : pesm_top

// ==== tb/pesm_host.sv ====
`timescale 1ns/1ps
module pesm_host (
    input wire logic i_clk,
    output logic o_awvalid,
    input wire logic i_awready,
    output logic [15:0] o_awaddr,
    output logic o_wvalid,
    input wire logic i_wready,
    output logic [31:0] o_wdata,
    output logic [3:0] o_wstrb,
    input wire logic i_bvalid,
    output logic o_bready,
    input wire logic [1:0] i_bresp,
    output logic o_arvalid,
    input wire logic i_arready,
    output logic [15:0] o_araddr,
    input wire logic i_rvalid,
    output logic o_rready,
    input wire logic [31:0] i_rdata,
    input wire logic [1:0] i_rresp
);
    initial begin
        {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = '0;
        {o_awaddr, o_araddr, o_wdata} = '0;
        o_wstrb = 4'hF;
    end
    // Released lines show the inverse so stale values never pass
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        {o_awvalid, o_wvalid, o_bready} <= 3'b111;
        o_awaddr <= a;
        o_wdata <= d;
        forever begin
            @(posedge i_clk);
            if (o_awvalid && i_awready) begin
                o_awvalid <= 1'b0;
                o_awaddr <= ~a;
            end
            if (o_wvalid && i_wready) begin
                o_wvalid <= 1'b0;
                o_wdata <= ~d;
            end
            if (i_bvalid) begin
                r = i_bresp;
                o_bready <= 1'b0;
                break;
            end
        end
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        {o_arvalid, o_rready} <= 2'b11;
        o_araddr <= a;
        forever begin
            @(posedge i_clk);
            if (o_arvalid && i_arready) begin
                o_arvalid <= 1'b0;
                o_araddr <= ~a;
            end
            if (i_rvalid) begin
                d = i_rdata;
                r = i_rresp;
                o_rready <= 1'b0;
                break;
            end
        end
    endtask : rd
endmodule : pesm_host

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "pesm_defines.svh"
module tb_top;
    import pesm_pkg::*;
    logic clk, rst_b, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, irq_b, irq_var;
    logic [15:0] awa, ara;
    logic [31:0] wd, rd, rd_var, sig, got, m_mask, m_stat, m_ph;
    logic [3:0] ws;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] sag, oc, ov, nla, nlr, nlf, nlp, ph;
    logic zxa, zxb, zxc, cvld, current_peak_period_end, voltage_peak_period_end, rdone;
    logic [23:0] phase_current_sum, ineu;
    int err_total, num_checks, cyc, t;
    int bits[8] = '{16, 17, 18, 19, 20, 23, 24, 25};
    int sh[3] = '{12, 3, 9};

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    pesm_host i_pesm_host (.i_clk(clk), .o_awvalid(awv), .i_awready(awr), .o_awaddr(awa),
        .o_wvalid(wv), .i_wready(wr), .o_wdata(wd), .o_wstrb(ws), .i_bvalid(bv),
        .o_bready(br), .i_bresp(bresp), .o_arvalid(arv), .i_arready(arr), .o_araddr(ara),
        .i_rvalid(rv), .o_rready(rr), .i_rdata(rd), .i_rresp(rresp));

    pesm_top i_pesm_top (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_AWVALID(awv), .O_AWREADY(awr),
        .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wr), .I_WDATA(wd), .I_WSTRB(ws),
        .O_BVALID(bv), .I_BREADY(br), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr),
        .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rr), .O_RDATA(rd), .O_RRESP(rresp),
        .I_SAG_PH(sag), .I_OVERCURRENT_PH(oc), .I_OVERVOLTAGE_PH(ov), .I_ZX_RISE_A(zxa),
        .I_ZX_RISE_B(zxb), .I_ZX_RISE_C(zxc), .I_CURRENT_VLD(cvld),
        .I_PHASE_CURRENT_SUM(phase_current_sum), .I_NEUTRAL_CURRENT_SAMPLE(ineu),
        .I_CURRENT_PEAK_END(current_peak_period_end), .I_VOLTAGE_PEAK_END(voltage_peak_period_end), .I_CONFIG_SIGNATURE(sig),
        .I_RESET_DONE(rdone), .I_TOTAL_NOLOAD_ACT(nla), .I_TOTAL_NOLOAD_REACT(nlr),
        .I_FUND_NOLOAD(nlf), .I_APPARENT_NOLOAD(nlp), .O_IRQ_B(irq_b));

    // Second build with no fundamental channel and active-only total no-load
    pesm_top #(.P_HAS_FUND(1'b0), .P_ACTIVE_ONLY(1'b1)) i_pesm_top_var (.I_SYS_CLK(clk),
        .I_RST_B(rst_b), .I_AWVALID(awv), .O_AWREADY(), .I_AWADDR(awa), .I_WVALID(wv),
        .O_WREADY(), .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(), .I_BREADY(br), .O_BRESP(),
        .I_ARVALID(arv), .O_ARREADY(), .I_ARADDR(ara), .O_RVALID(), .I_RREADY(rr),
        .O_RDATA(rd_var), .O_RRESP(), .I_SAG_PH(sag), .I_OVERCURRENT_PH(oc),
        .I_OVERVOLTAGE_PH(ov), .I_ZX_RISE_A(zxa), .I_ZX_RISE_B(zxb), .I_ZX_RISE_C(zxc),
        .I_CURRENT_VLD(cvld), .I_PHASE_CURRENT_SUM(phase_current_sum), .I_NEUTRAL_CURRENT_SAMPLE(ineu),
        .I_CURRENT_PEAK_END(current_peak_period_end), .I_VOLTAGE_PEAK_END(voltage_peak_period_end), .I_CONFIG_SIGNATURE(sig),
        .I_RESET_DONE(rdone), .I_TOTAL_NOLOAD_ACT(nla), .I_TOTAL_NOLOAD_REACT(nlr),
        .I_FUND_NOLOAD(nlf), .I_APPARENT_NOLOAD(nlp), .O_IRQ_B(irq_var));

    task automatic complete_run();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
        i_pesm_host.rd(a, got, resp);
        chk(got, e);
    endtask : rd_chk

    // One-cycle event pulse; phase order needs A then C on the next cycle
    task automatic fire(input int k, input logic [2:0] p);
        @(posedge clk);
        case (k)
            0: sag <= p;
            1: oc <= p;
            2: ov <= p;
            3: zxa <= 1'b1;
            4: cvld <= 1'b1;
            5: current_peak_period_end <= 1'b1;
            6: voltage_peak_period_end <= 1'b1;
            7: sig <= ~sig;
            default: rdone <= 1'b1;
        endcase
        @(posedge clk);
        {sag, oc, ov, zxa, cvld, current_peak_period_end, voltage_peak_period_end, rdone} <= '0;
        zxc <= (k == 3);
        @(posedge clk);
        zxc <= 1'b0;
        #1;
    endtask : fire

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        rst_b = 1'b0;
        {sag, oc, ov, nla, nlr, nlf, nlp, zxa, zxb, zxc, cvld, current_peak_period_end, voltage_peak_period_end, rdone} = '0;
        {phase_current_sum, ineu} = '0;
        sig = 32'h0000_1234;
        {err_total, num_checks, cyc} = '0;
        void'($urandom(72));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk({31'b0, irq_b}, 32'h1);
        rd_chk(`PESM_ADDR_PHASE_SRC, 32'h0);
        rd_chk(`PESM_ADDR_NOLOAD, 32'h0);
        rd_chk(`PESM_ADDR_MASK, 32'h0);
        i_pesm_host.wr(`PESM_ADDR_MASK, 32'hFFFF_FFFF, resp);
        chk({30'b0, resp}, {30'b0, `PESM_RESP_OKAY});
        rd_chk(`PESM_ADDR_MASK, `PESM_MASK_WR);
        chk({30'b0, resp}, {30'b0, `PESM_RESP_OKAY});
        i_pesm_host.wr(16'hE700, 32'h0000_0001, resp);
        chk({30'b0, resp}, {30'b0, `PESM_RESP_SLVERR});
        rd_chk(16'hE700, 32'h0);
        chk({30'b0, resp}, {30'b0, `PESM_RESP_SLVERR});
        t = $urandom_range(0, 1000);
        i_pesm_host.wr(`PESM_ADDR_THRESH, 32'(t), resp);
        // Pass with the event's mask bit cleared first; mismatch pass at threshold stays quiet
        for (int k = 0; k < 8; k++) begin
            for (int en = 0; en < 2; en++) begin
                ph = 3'($urandom_range(1, 7));
                m_mask = (en != 0) ? ((32'h1 << bits[k]) | ($urandom() & 32'h0000_8000))
                    : ($urandom() & ~(32'h1 << bits[k]));
                i_pesm_host.wr(`PESM_ADDR_MASK, m_mask, resp);
                phase_current_sum <= 24'(t + en);
                m_stat = (k == 4 && en == 0) ? 32'h0 : (32'h1 << bits[k]);
                m_ph = (k < 3) ? (32'(ph) << sh[k]) : 32'h0;
                fire(k, ph);
                chk({31'b0, irq_b}, {31'b0, en == 0});
                rd_chk(`PESM_ADDR_STATUS, m_stat);
                rd_chk(`PESM_ADDR_PHASE_SRC, m_ph);
                i_pesm_host.wr(`PESM_ADDR_STATUS, 32'hFFFF_FFFF, resp);
                @(posedge clk);
                #1;
                chk({31'b0, irq_b}, 32'h1);
                rd_chk(`PESM_ADDR_PHASE_SRC, 32'h0);
            end
        end
        i_pesm_host.wr(`PESM_ADDR_MASK, 32'h0, resp);
        fire(8, 3'b0);
        chk({31'b0, irq_b}, 32'h0);
        rd_chk(`PESM_ADDR_STATUS, 32'h0000_8000);
        i_pesm_host.wr(`PESM_ADDR_STATUS, 32'hFFFF_FFFF, resp);
        @(posedge clk);
        {nla, nlr, nlf, nlp} <= 12'($urandom() | 32'h0000_0249);
        repeat (3) @(posedge clk);
        #1;
        rd_chk(`PESM_ADDR_NOLOAD, {23'b0, nlp, nlf, nla & nlr});
        chk(rd_var, {23'b0, nlp, 3'b000, nla});
        rd_chk(`PESM_ADDR_STATUS, {29'b0, |nlp, |nlf, |(nla & nlr)});
        chk(rd_var, {29'b0, |nlp, 1'b0, |nla});
        chk({31'b0, irq_b}, 32'h1);
        chk({31'b0, irq_var}, 32'h1);
        complete_run();
    end
endmodule : tb_top
